// File: hdl/srs_pkg.sv
package srs_pkg;

    // ==========================================================
    // clock and timing
    localparam int CLK_PERIOD_NS  = 100;
    localparam int NS_PER_US      = 1000;
    localparam int NS_PER_MS      = 1000000;
    localparam int POR_TIME_MS    = 23;
    localparam int PIN_TIME_US    = 760;
    localparam int BYTE_TIME_US   = 91;
    localparam int PHY_TIME_US    = 110;
    localparam int VPHY_TIME_US   = 1;

    localparam int POR_CYCLES     = (POR_TIME_MS * NS_PER_MS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PIN_CYCLES     = (PIN_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int BYTE_CYCLES    = (BYTE_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PHY_CYCLES     = (PHY_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int VPHY_CYCLES    = (VPHY_TIME_US * NS_PER_US + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ==========================================================
    // widths
    localparam int HOLD_W         = 18;
    localparam int BYTE_W         = 10;
    localparam int PHY_CNT_W      = 11;
    localparam int STRAP_W        = 8;
    localparam int NUM_PHY        = 3;
    localparam int VPHY_IDX       = 2;

    // ==========================================================
    // values
    localparam logic [31:0] BYTE_TEST_PATTERN = 32'h8765_4321;
    localparam logic [31:0] BYTE_TEST_INVALID = 32'h0000_0000;
    localparam logic [STRAP_W-1:0] STRAP_RESET = 8'h00;

    // ==========================================================
    // sequencer states
    typedef enum logic [2:0] {
        ST_CHIP_HOLD,
        ST_LATCH,
        ST_LOAD,
        ST_READY,
        ST_SOFT
    } srs_state_t;

endpackage

// File: hdl/srs_phy_reset_timer.sv
`timescale 1ns/10ps

module srs_phy_reset_timer
    import srs_pkg::*;
#(
    parameter int CYCLES = PHY_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic resetn_i,
    // reset sources
    input  wire logic chip_rst_i,
    input  wire logic rc_set_i,
    input  wire logic basic_set_i,
    input  wire logic pd_exit_i,
    // status and resets
    output logic      rc_bit_o,
    output logic      basic_bit_o,
    output logic      phy_reset_n_o,
    output logic      reg_reset_n_o,
    output logic      prot_reset_n_o
);

    localparam logic [PHY_CNT_W-1:0] LAST = PHY_CNT_W'(CYCLES - 1);

    logic [PHY_CNT_W-1:0] cnt_reg;
    logic                 busy_reg;
    logic                 done;
    logic                 start;

    assign start = rc_set_i | basic_set_i | pd_exit_i;
    assign done  = busy_reg && (cnt_reg == LAST);

    // ==========================================================
    // timer
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            busy_reg <= 1'b0;
            cnt_reg  <= '0;
        end else if (start || chip_rst_i) begin
            busy_reg <= start;
            cnt_reg  <= '0;
        end else if (done) begin
            busy_reg <= 1'b0;
        end else if (busy_reg) begin
            cnt_reg  <= cnt_reg + 1'b1;
        end
    end

    // ==========================================================
    // self-clearing bits, set wins over clear
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rc_bit_o    <= 1'b0;
            basic_bit_o <= 1'b0;
        end else if (chip_rst_i) begin
            rc_bit_o    <= 1'b0;
            basic_bit_o <= 1'b0;
        end else begin
            rc_bit_o    <= rc_set_i | (rc_bit_o & ~done);
            basic_bit_o <= basic_set_i | (basic_bit_o & ~done);
        end
    end

    // ==========================================================
    // reset outputs
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            phy_reset_n_o  <= 1'b0;
            reg_reset_n_o  <= 1'b0;
            prot_reset_n_o <= 1'b0;
        end else if (chip_rst_i) begin
            phy_reset_n_o  <= 1'b0;
            reg_reset_n_o  <= 1'b0;
            prot_reset_n_o <= 1'b0;
        end else begin
            phy_reset_n_o  <= ~(start | (busy_reg & ~done));
            reg_reset_n_o  <= ~((rc_set_i | basic_set_i) | ((rc_bit_o | basic_bit_o) & ~done));
            prot_reset_n_o <= ~(rc_set_i | (rc_bit_o & ~done));
        end
    end

    // ==========================================================
    // checks
    AST_BIT_SELF_CLEARS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (done && !rc_set_i && !basic_set_i && !chip_rst_i) |=> (!rc_bit_o && !basic_bit_o))
        else $error("phy reset bit did not self-clear");

    AST_BASIC_KEEPS_PROT: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (basic_set_i && !rc_set_i && !rc_bit_o && !chip_rst_i) |=> prot_reset_n_o)
        else $error("basic reset bit cleared protected bits");

    AST_PD_KEEPS_REGS: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (pd_exit_i && !rc_set_i && !basic_set_i && !rc_bit_o && !basic_bit_o && !chip_rst_i)
        |=> (!phy_reset_n_o && reg_reset_n_o))
        else $error("power-down exit reset touched registers");

    COV_PHY_RESET_DONE: cover property (@(posedge clk_i) disable iff (!resetn_i)
        $fell(rc_bit_o));

endmodule // srs_phy_reset_timer

// File: hdl/srs_reset_sequencer.sv
`timescale 1ns/10ps

// Operation
// - power-on or pin reset asserts all resets, latches straps, then runs loader
// - straps captured only once every chip-level reset source is released
// - external reset pin low starts a full chip-level reset
// - core soft reset resets everything except the three PHYs and the protected bits
// - core soft reset reruns loader without re-latching straps
// - core soft reset keeps bits not affected by soft reset
// - endian probe reads invalid until serial resets finish, then fixed pattern
// - ready set after reset completes; host polls probe then ready
// - writes before ready are invalid; host waits for ready
// - power-on reset takes about 23 ms plus 91 us per loaded byte
// - pin reset takes about 760 us plus 91 us per loaded byte
// - core soft reset takes about 760 us plus 91 us per byte
// - single PHY reset affects that PHY only; no strap latch, no loader
// - port 2 PHY reset by control or basic bit; both self-clear
// - port 2 PHY reset bits clear about 110 us after trigger
// - leaving power-down resets the PHY without touching its registers
// - basic control reset bit keeps bits not affected by soft reset
// - port 1 PHY reset like port 2, bits clear after 110 us
// - virtual PHY reset by either bit, self-clears after 1 us
module srs_reset_sequencer
    import srs_pkg::*;
#(
    parameter int POR_HOLD_CYCLES = POR_CYCLES,
    parameter int PIN_HOLD_CYCLES = PIN_CYCLES
) (
    // clock and power-on reset
    input  wire logic                 clk_i,
    input  wire logic                 resetn_i,
    // pins
    input  wire logic                 ext_reset_n_i,
    input  wire logic [STRAP_W-1:0]   straps_i,
    // reset control register writes
    input  wire logic                 core_soft_reset_set_i,
    input  wire logic [NUM_PHY-1:0]   phy_rc_reset_set_i,
    // phy basic control and power state
    input  wire logic [NUM_PHY-1:0]   phy_basic_reset_set_i,
    input  wire logic [NUM_PHY-1:0]   phy_pd_exit_i,
    // eeprom loader
    input  wire logic                 loader_done_i,
    // host access
    input  wire logic                 host_write_i,
    // eeprom loader control
    output logic                      loader_start_o,
    output logic                      loader_byte_tick_o,
    // internal resets
    output logic                      core_reset_n_o,
    output logic                      prot_reset_n_o,
    output logic                      serial_if_reset_n_o,
    output logic [NUM_PHY-1:0]        phy_reset_n_o,
    output logic [NUM_PHY-1:0]        phy_reg_reset_n_o,
    output logic [NUM_PHY-1:0]        phy_prot_reset_n_o,
    // status
    output logic [STRAP_W-1:0]        straps_latched_o,
    output logic                      core_soft_reset_bit_o,
    output logic [NUM_PHY-1:0]        phy_rc_reset_bit_o,
    output logic [NUM_PHY-1:0]        phy_basic_reset_bit_o,
    output logic                      ready_o,
    output logic [31:0]               byte_test_o,
    output logic                      host_write_ok_o,
    output logic                      host_write_invalid_o
);

    localparam logic [HOLD_W-1:0] POR_LAST  = HOLD_W'(POR_HOLD_CYCLES - 1);
    localparam logic [HOLD_W-1:0] PIN_LAST  = HOLD_W'(PIN_HOLD_CYCLES - 1);
    localparam logic [BYTE_W-1:0] BYTE_LAST = BYTE_W'(BYTE_CYCLES - 1);

    // ==========================================================
    // declarations
    srs_state_t           state_reg;
    srs_state_t           state_next;
    logic                 ext_meta_reg;
    logic                 ext_sync_reg;
    logic [STRAP_W-1:0]   strap_meta_reg;
    logic [STRAP_W-1:0]   strap_sync_reg;
    logic                 por_reg;
    logic [HOLD_W-1:0]    hold_cnt_reg;
    logic [HOLD_W-1:0]    hold_last;
    logic [BYTE_W-1:0]    byte_cnt_reg;
    logic                 hold_done;
    logic                 chip_rst;

    // ==========================================================
    // pin synchronisers
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ext_meta_reg   <= 1'b0;
            ext_sync_reg   <= 1'b0;
            strap_meta_reg <= STRAP_RESET;
            strap_sync_reg <= STRAP_RESET;
        end else begin
            ext_meta_reg   <= ext_reset_n_i;
            ext_sync_reg   <= ext_meta_reg;
            strap_meta_reg <= straps_i;
            strap_sync_reg <= strap_meta_reg;
        end
    end

    // ==========================================================
    // sequencer
    assign hold_last = por_reg ? POR_LAST : PIN_LAST;
    assign hold_done = (hold_cnt_reg == hold_last);
    assign chip_rst  = (state_reg == ST_CHIP_HOLD);

    always_comb begin
        state_next = state_reg;
        if (!ext_sync_reg) begin
            state_next = ST_CHIP_HOLD;
        end else begin
            case (state_reg)
                ST_CHIP_HOLD: begin
                    if (hold_done) begin
                        state_next = ST_LATCH;
                    end
                end
                ST_LATCH: begin
                    state_next = ST_LOAD;
                end
                ST_LOAD: begin
                    if (core_soft_reset_set_i) begin
                        state_next = ST_SOFT;
                    end else if (loader_done_i) begin
                        state_next = ST_READY;
                    end
                end
                ST_READY: begin
                    if (core_soft_reset_set_i) begin
                        state_next = ST_SOFT;
                    end
                end
                ST_SOFT: begin
                    if (core_soft_reset_set_i) begin
                        state_next = ST_SOFT;
                    end else if (hold_done) begin
                        state_next = ST_LOAD;
                    end
                end
                default: begin
                    state_next = ST_CHIP_HOLD;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg <= ST_CHIP_HOLD;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // reset duration
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            por_reg      <= 1'b1;
            hold_cnt_reg <= '0;
        end else begin
            if (!ext_sync_reg && state_reg != ST_CHIP_HOLD) begin
                por_reg <= 1'b0;
            end else if (core_soft_reset_set_i && state_reg != ST_CHIP_HOLD) begin
                por_reg <= 1'b0;
            end
            if (state_next != state_reg || !ext_sync_reg || (core_soft_reset_set_i && state_reg != ST_CHIP_HOLD)) begin
                hold_cnt_reg <= '0;
            end else if ((state_reg == ST_CHIP_HOLD || state_reg == ST_SOFT) && !hold_done) begin
                hold_cnt_reg <= hold_cnt_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // strap latch
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            straps_latched_o <= STRAP_RESET;
        end else if (state_reg == ST_LATCH) begin
            straps_latched_o <= strap_sync_reg;
        end
    end

    // ==========================================================
    // eeprom loader start and byte pacing
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            loader_start_o     <= 1'b0;
            loader_byte_tick_o <= 1'b0;
            byte_cnt_reg       <= '0;
        end else begin
            loader_start_o     <= (state_next == ST_LOAD) && (state_reg != ST_LOAD);
            loader_byte_tick_o <= (state_next == ST_LOAD) && (state_reg == ST_LOAD) && (byte_cnt_reg == BYTE_LAST);
            if (state_reg != ST_LOAD || byte_cnt_reg == BYTE_LAST) begin
                byte_cnt_reg <= '0;
            end else begin
                byte_cnt_reg <= byte_cnt_reg + 1'b1;
            end
        end
    end

    // ==========================================================
    // internal resets
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_reset_n_o      <= 1'b0;
            prot_reset_n_o      <= 1'b0;
            serial_if_reset_n_o <= 1'b0;
        end else begin
            core_reset_n_o      <= ~(state_next == ST_CHIP_HOLD || state_next == ST_SOFT);
            prot_reset_n_o      <= ~(state_next == ST_CHIP_HOLD);
            serial_if_reset_n_o <= ~(state_next == ST_CHIP_HOLD || state_next == ST_SOFT);
        end
    end

    // ==========================================================
    // status
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            core_soft_reset_bit_o <= 1'b0;
            ready_o               <= 1'b0;
            byte_test_o           <= BYTE_TEST_INVALID;
        end else begin
            if (state_next == ST_CHIP_HOLD) begin
                core_soft_reset_bit_o <= 1'b0;
            end else if (core_soft_reset_set_i) begin
                core_soft_reset_bit_o <= 1'b1;
            end else if (state_next == ST_READY) begin
                core_soft_reset_bit_o <= 1'b0;
            end
            ready_o     <= (state_next == ST_READY);
            byte_test_o <= (state_next == ST_CHIP_HOLD || state_next == ST_SOFT)
                           ? BYTE_TEST_INVALID : BYTE_TEST_PATTERN;
        end
    end

    // ==========================================================
    // host write screening
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            host_write_ok_o      <= 1'b0;
            host_write_invalid_o <= 1'b0;
        end else begin
            host_write_ok_o      <= host_write_i & ready_o;
            host_write_invalid_o <= host_write_i & ~ready_o;
        end
    end

    // ==========================================================
    // single-module phy resets
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PHY; gi++) begin : g_phy
            srs_phy_reset_timer #(
                .CYCLES (gi == VPHY_IDX ? VPHY_CYCLES : PHY_CYCLES)
            ) u_timer (
                .clk_i          (clk_i),
                .resetn_i       (resetn_i),
                .chip_rst_i     (chip_rst),
                .rc_set_i       (phy_rc_reset_set_i[gi]),
                .basic_set_i    (phy_basic_reset_set_i[gi]),
                .pd_exit_i      (phy_pd_exit_i[gi]),
                .rc_bit_o       (phy_rc_reset_bit_o[gi]),
                .basic_bit_o    (phy_basic_reset_bit_o[gi]),
                .phy_reset_n_o  (phy_reset_n_o[gi]),
                .reg_reset_n_o  (phy_reg_reset_n_o[gi]),
                .prot_reset_n_o (phy_prot_reset_n_o[gi])
            );
        end
    endgenerate

    // ==========================================================
    // checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    AST_PIN_STARTS_CHIP_RESET: assert property (!ext_sync_reg |=> (chip_rst && !core_reset_n_o))
        else $error("pin reset did not start chip reset");

    AST_STRAPS_ONLY_ON_LATCH: assert property (!$stable(straps_latched_o) |-> $past(state_reg) == ST_LATCH)
        else $error("straps changed outside latch");

    AST_LOADER_AFTER_RESET: assert property ($rose(loader_start_o)
        |-> ($past(state_reg) == ST_LATCH || $past(state_reg) == ST_SOFT))
        else $error("loader started without a reset");

    AST_SOFT_NO_STRAPS: assert property ((state_reg == ST_SOFT) |=> $stable(straps_latched_o))
        else $error("soft reset re-latched straps");

    AST_SOFT_KEEPS_PROT_PHY: assert property ((state_reg == ST_SOFT && ext_sync_reg) |=> (prot_reset_n_o && !chip_rst))
        else $error("soft reset reached protected bits or phys");

    AST_PROBE_INVALID: assert property (!serial_if_reset_n_o |-> (byte_test_o == BYTE_TEST_INVALID))
        else $error("probe valid during serial reset");

    AST_READY_AFTER_LOADER: assert property ($rose(ready_o) |-> ($past(loader_done_i) && $past(state_reg) == ST_LOAD))
        else $error("ready without loader completion");

    AST_EARLY_WRITE_INVALID: assert property ((host_write_i && !ready_o) |=> (host_write_invalid_o && !host_write_ok_o))
        else $error("early write not rejected");

    AST_SOFT_DURATION: assert property ((state_reg == ST_SOFT && state_next == ST_LOAD) |-> hold_cnt_reg == PIN_LAST)
        else $error("soft reset hold length wrong");

    AST_SOFT_BIT_SELF_CLEARS: assert property ($rose(ready_o) |-> !core_soft_reset_bit_o)
        else $error("soft reset bit still set at ready");

    COV_READY: cover property ($rose(ready_o));
    COV_SOFT_DONE: cover property ((state_reg == ST_SOFT) ##1 (state_reg == ST_LOAD));
    COV_PIN_RESET: cover property ((state_reg == ST_READY) ##1 !ext_sync_reg);

endmodule // srs_reset_sequencer

// File: tb/srs_loader_host_model.sv
`timescale 1ns/10ps

// ==========================================================
// loader and polling host at the far side
module srs_loader_host_model
    import srs_pkg::*;
#(
    parameter int LOAD_BYTES = 2
) (
    // clock
    input  wire logic        clk_i,
    // loader handshake
    input  wire logic        loader_start_i,
    input  wire logic        byte_tick_i,
    output logic             loader_done_o,
    // polled status
    input  wire logic [31:0] byte_test_i,
    input  wire logic        ready_i,
    output logic             order_ok_o
);
    int  n_bytes;
    bit  busy;

    initial begin
        loader_done_o = 1'b0;
        order_ok_o    = 1'b1;
        busy          = 1'b0;
    end

    // loader answers after the paced bytes
    always @(negedge clk_i) begin
        if (loader_start_i === 1'b1) begin
            busy    = 1'b1;
            n_bytes = 0;
        end else if (busy && byte_tick_i === 1'b1) begin
            n_bytes++;
        end
        loader_done_o <= busy && (n_bytes == LOAD_BYTES);
        if (n_bytes == LOAD_BYTES) busy = 1'b0;
    end

    // host polls probe first, then ready
    always @(negedge clk_i) begin
        if (ready_i === 1'b1 && byte_test_i !== BYTE_TEST_PATTERN) order_ok_o <= 1'b0;
    end
endmodule // srs_loader_host_model

// File: tb/tb_switch_reset_sequencer.sv
`timescale 1ns/10ps

module tb_switch_reset_sequencer
    import srs_pkg::*;
;
    localparam int POR_H = 40;
    localparam int PIN_H = 20;
    localparam int NB    = 2;
    logic clk_i = 0, resetn_i = 0, ext_reset_n_i = 1, soft_i = 0, loader_done, host_write_i = 0, order_ok;
    logic [STRAP_W-1:0] straps_i, straps_exp;
    logic [NUM_PHY-1:0] rc_set = 0, basic_set = 0, pd_exit = 0, phy_n, phy_reg_n, phy_prot_n, rc_bit, basic_bit;
    logic loader_start, tick, core_n, prot_n, serial_n, soft_bit, ready_o, wr_ok, wr_inv;
    logic [STRAP_W-1:0] straps_lat;
    logic [31:0] byte_test;
    logic exp_q[$];
    int fails = 0, checks_done = 0, starts = 0, n;

    srs_reset_sequencer #(.POR_HOLD_CYCLES(POR_H), .PIN_HOLD_CYCLES(PIN_H)) u_dut (
        .clk_i(clk_i), .resetn_i(resetn_i), .ext_reset_n_i(ext_reset_n_i), .straps_i(straps_i),
        .core_soft_reset_set_i(soft_i), .phy_rc_reset_set_i(rc_set), .phy_basic_reset_set_i(basic_set),
        .phy_pd_exit_i(pd_exit), .loader_done_i(loader_done), .host_write_i(host_write_i),
        .loader_start_o(loader_start), .loader_byte_tick_o(tick), .core_reset_n_o(core_n),
        .prot_reset_n_o(prot_n), .serial_if_reset_n_o(serial_n), .phy_reset_n_o(phy_n),
        .phy_reg_reset_n_o(phy_reg_n), .phy_prot_reset_n_o(phy_prot_n), .straps_latched_o(straps_lat),
        .core_soft_reset_bit_o(soft_bit), .phy_rc_reset_bit_o(rc_bit), .phy_basic_reset_bit_o(basic_bit),
        .ready_o(ready_o), .byte_test_o(byte_test), .host_write_ok_o(wr_ok), .host_write_invalid_o(wr_inv));

    srs_loader_host_model #(.LOAD_BYTES(NB)) u_far (
        .clk_i(clk_i), .loader_start_i(loader_start), .byte_tick_i(tick), .loader_done_o(loader_done),
        .byte_test_i(byte_test), .ready_i(ready_o), .order_ok_o(order_ok));

    // ==========================================================
    // clock, watchdog, monitors
    initial forever #50 clk_i = ~clk_i;
    initial begin
        #(40000 * 100);
        fails++;
        summarize();
    end
    always @(negedge clk_i) if (loader_start === 1'b1) starts++;
    always @(posedge clk_i) begin
        #1;
        if (wr_ok === 1'b1 || wr_inv === 1'b1) begin
            check(exp_q.size() > 0, 1);
            if (exp_q.size() > 0) begin
                check(wr_ok, exp_q[0]);
                check(wr_inv, !exp_q.pop_front());
            end
        end
    end

    // ==========================================================
    // shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic host_wr(input logic ok);
        @(negedge clk_i);
        host_write_i = 1'b1;
        exp_q.push_back(ok);
        @(negedge clk_i);
        host_write_i = 1'b0;
    endtask

    // hold length, then loader pacing until ready
    task automatic wait_seq(input int hold);
        n = 0;
        while (loader_start !== 1'b1 && n < 20000) begin
            @(negedge clk_i);
            n++;
        end
        check(n >= hold && n <= hold + 8, 1);
        n = 0;
        while (ready_o !== 1'b1 && n < 5000) begin
            @(negedge clk_i);
            n++;
        end
        check(n >= NB * BYTE_CYCLES && n <= NB * BYTE_CYCLES + 6, 1);
        check(byte_test, BYTE_TEST_PATTERN);
        host_wr(1'b1);
    endtask

    // src 0 control bit, 1 basic bit, 2 power-down exit
    task automatic phy_case(input int i, input int src);
        int s0;
        s0 = starts;
        @(negedge clk_i);
        straps_i = $urandom;
        if (src == 0) rc_set[i] = 1'b1;
        if (src == 1) basic_set[i] = 1'b1;
        if (src == 2) pd_exit[i] = 1'b1;
        @(negedge clk_i);
        {rc_set, basic_set, pd_exit} = '0;
        check(phy_n, 3'(~(3'b001 << i)));
        check(phy_reg_n[i], src == 2);
        check(phy_prot_n[i], src != 0);
        check({rc_bit[i], basic_bit[i]}, {src == 0, src == 1});
        n = 0;
        while (phy_n[i] !== 1'b1 && n < 3000) begin
            @(negedge clk_i);
            n++;
        end
        check(n + 2 >= (i == VPHY_IDX ? VPHY_CYCLES : PHY_CYCLES), 1);
        check(n <= (i == VPHY_IDX ? VPHY_CYCLES : PHY_CYCLES) + 3, 1);
        check({rc_bit[i], basic_bit[i], core_n, ready_o}, 4'b0011);
        check({straps_lat, starts - s0}, {straps_exp, 32'h0000_0000});
    endtask

    // ==========================================================
    // tests
    initial begin
        n = $urandom(32'h0000_b09c);
        straps_i = $urandom;
        straps_exp = straps_i;
        repeat (2) @(negedge clk_i);
        resetn_i = 1'b1;
        check({core_n, prot_n, phy_n, ready_o}, 6'b000000);
        check(byte_test, BYTE_TEST_INVALID);
        host_wr(1'b0);
        wait_seq(POR_H - 4);
        check(straps_lat, straps_exp);
        $display("test power-on done");

        ext_reset_n_i = 1'b0;
        straps_i = $urandom;
        repeat (4) @(negedge clk_i);
        check({core_n, prot_n, serial_n, phy_n, phy_prot_n, ready_o}, 0);
        check(byte_test, BYTE_TEST_INVALID);
        straps_i = $urandom;
        straps_exp = straps_i;
        @(negedge clk_i);
        ext_reset_n_i = 1'b1;
        wait_seq(PIN_H);
        check(straps_lat, straps_exp);
        $display("test pin reset done");

        straps_i = $urandom;
        soft_i = 1'b1;
        @(negedge clk_i);
        soft_i = 1'b0;
        check({core_n, prot_n, serial_n, soft_bit, ready_o}, 5'b01010);
        check({phy_n, phy_reg_n, phy_prot_n, byte_test}, {9'h1ff, BYTE_TEST_INVALID});
        host_wr(1'b0);
        wait_seq(PIN_H - 4);
        check({straps_lat, soft_bit}, {straps_exp, 1'b0});
        $display("test soft reset done");

        for (int i = 0; i < NUM_PHY; i++) for (int s = 0; s < 3; s++) phy_case(i, s);
        check(order_ok, 1);
        check(exp_q.size(), 0);
        $display("test phy resets done");
        summarize();
    end
endmodule // tb_switch_reset_sequencer
